// ### design/irq_flag_consts.vh
/*
 interrupt enable/flag block constants: register offsets, bit positions,
 reset values. assumes an axi4-lite register bus with 32-bit words.
*/
`ifndef IRQ_FLAG_CONSTS_VH
`define IRQ_FLAG_CONSTS_VH

// register indices as printed (byte address is four times the index)
`define IDX_CORE_CTRL      9'h00b
`define IDX_CORE_CTRL_B1   9'h08b
`define IDX_CORE_CTRL_B2   9'h10b
`define IDX_CORE_CTRL_B3   9'h18b
`define IDX_PERIPH_FLAGS1  9'h00c
`define IDX_PERIPH_FLAGS2  9'h00d
`define IDX_PERIPH_EN1     9'h08c
`define IDX_PERIPH_EN2     9'h08d
// source edge/config register, index chosen freely
`define IDX_SRC_CFG        9'h1f0

// core control bit positions
`define BIT_GLOBAL_EN      7
`define BIT_PERIPH_EN      6
`define BIT_TMRA_EN        5
`define BIT_EXT_EN         4
`define BIT_PORT_EN        3
`define BIT_TMRA_FLAG      2
`define BIT_EXT_FLAG       1
`define BIT_PORT_FLAG      0

// peripheral bit positions
`define BIT_UART_RX        5
`define BIT_UART_TX        4

// reset values
`define RST_CORE_CTRL      8'h00
`define RST_PERIPH         8'h00

// axi responses
`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10

`endif

// ### design/irq_flag_logic.v
/*
 interrupt enable and flag logic with an axi4-lite register slave.
 assumes event inputs are one-cycle pulses on SYS_CLK_IN; the external
 pin and port pins come from outside and are synchronised here.
*/
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "irq_flag_consts.vh"

// Function
// - request passes to the core only while global enable is set
// - peripheral requests also need the peripheral group enable
// - flags set on their event regardless of any enable
// - core control layout fixed, visible at all four bank addresses
// - timer a overflow sets its flag, held until software clears
// - selected edge on external pin sets its flag, software clears
// - port mismatch keeps setting flag; port read ends mismatch
// - peripheral enable register one holds eight enables, reset zero
// - peripheral flag register one mirrors enable register one layout
// - uart rx and tx flags read-only, show buffer levels
// - adc conversion completion sets adc flag, software clears
// - serial port flag set on transfer or completed bus condition
// - serial port flag set on start/stop seen while idle
// - capcmp one flag set on capture or compare, unused in pwm
// - timer c period match and timer b overflow set flags
// - peripheral enable two implements bit 0 only, rest read zero
module irq_flag_logic #(
   parameter PORT_W = 4
) (
   input  wire              SYS_CLK_IN,
   input  wire              RESETN_IN,
   // axi4-lite slave
   input  wire [11:0]       S_AXI_AWADDR_IN,
   input  wire              S_AXI_AWVALID_IN,
   output wire              S_AXI_AWREADY_OUT,
   input  wire [31:0]       S_AXI_WDATA_IN,
   input  wire [3:0]        S_AXI_WSTRB_IN,
   input  wire              S_AXI_WVALID_IN,
   output wire              S_AXI_WREADY_OUT,
   output reg  [1:0]        S_AXI_BRESP_OUT,
   output reg               S_AXI_BVALID_OUT,
   input  wire              S_AXI_BREADY_IN,
   input  wire [11:0]       S_AXI_ARADDR_IN,
   input  wire              S_AXI_ARVALID_IN,
   output wire              S_AXI_ARREADY_OUT,
   output reg  [31:0]       S_AXI_RDATA_OUT,
   output reg  [1:0]        S_AXI_RRESP_OUT,
   output reg               S_AXI_RVALID_OUT,
   input  wire              S_AXI_RREADY_IN,
   // event sources: one-cycle pulses, except pin, port, uart, idle and pwm levels
   input  wire              TIMER_A_OVF_IN,
   input  wire              EXT_IRQ_PIN_IN,
   input  wire [PORT_W-1:0] PORT_PINS_IN,
   input  wire              PORT_READ_IN,
   input  wire              PARALLEL_PORT_EVT_IN,
   input  wire              ADC_DONE_IN,
   input  wire              UART_RX_FULL_IN,
   input  wire              UART_TX_EMPTY_IN,
   input  wire              SERIAL_XFER_DONE_IN,
   input  wire              SERIAL_COND_DONE_IN,
   input  wire              SERIAL_BUS_COND_IN,
   input  wire              SERIAL_IDLE_IN,
   input  wire              CAPCMP_ONE_EVT_IN,
   input  wire              CAPCMP_ONE_PWM_IN,
   input  wire              CAPCMP_TWO_EVT_IN,
   input  wire              CAPCMP_TWO_PWM_IN,
   input  wire              TIMER_C_MATCH_IN,
   input  wire              TIMER_B_OVF_IN,
   // to core
   output reg               CORE_IRQ_OUT
);

   reg  [7:0]        core_ctrl_q;
   reg  [7:0]        pen1_q;
   reg               pen2_q;
   reg  [7:0]        pflag1_q;
   reg               pflag2_q;
   reg               ext_edge_rise_q;
   reg  [1:0]        ext_sync_q;
   reg               ext_prev_q;
   reg  [PORT_W-1:0] port_s1_q;
   reg  [PORT_W-1:0] port_s2_q;
   reg  [PORT_W-1:0] port_latch_q;
   reg               aw_hold_q;
   reg  [8:0]        aw_idx_q;
   reg               w_hold_q;
   reg  [7:0]        w_data_q;
   reg               w_strb_q;

   wire       ext_edge;
   wire       port_mismatch;
   wire [7:0] pset1;
   wire       pset2;
   wire       do_write;
   wire       core_hit;
   wire       f1_hit;
   wire       f2_hit;
   wire       e1_hit;
   wire       e2_hit;
   wire       cfg_hit;
   wire       wr_ok;
   wire [8:0] ar_idx;
   reg  [7:0] rd_val;
   reg        rd_ok;

   // external pin and port pin synchronisers
   always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         ext_sync_q <= 2'b00;
         ext_prev_q <= 1'b0;
         port_s1_q  <= {PORT_W{1'b0}};
         port_s2_q  <= {PORT_W{1'b0}};
      end else begin
         ext_sync_q <= {ext_sync_q[0], EXT_IRQ_PIN_IN};
         ext_prev_q <= ext_sync_q[1];
         port_s1_q  <= PORT_PINS_IN;
         port_s2_q  <= port_s1_q;
      end
   end

   // selected edge on the synchronised pin
   assign ext_edge = ext_edge_rise_q ? (ext_sync_q[1] & ~ext_prev_q)
                                     : (~ext_sync_q[1] & ext_prev_q);
   assign port_mismatch = (port_s2_q != port_latch_q);

   // last latched port value, refreshed by a port read
   always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         port_latch_q <= {PORT_W{1'b0}};
      end else if (PORT_READ_IN) begin
         port_latch_q <= port_s2_q;
      end
   end

   // peripheral set conditions, same positions as enables
   assign pset1 = {PARALLEL_PORT_EVT_IN,
                   ADC_DONE_IN,
                   1'b0,
                   1'b0,
                   SERIAL_XFER_DONE_IN | SERIAL_COND_DONE_IN
                   | (SERIAL_BUS_COND_IN & SERIAL_IDLE_IN),
                   CAPCMP_ONE_EVT_IN & ~CAPCMP_ONE_PWM_IN,
                   TIMER_C_MATCH_IN,
                   TIMER_B_OVF_IN};
   assign pset2 = CAPCMP_TWO_EVT_IN & ~CAPCMP_TWO_PWM_IN;

   // axi write: address and data taken in either order
   assign S_AXI_AWREADY_OUT = ~aw_hold_q & ~S_AXI_BVALID_OUT;
   assign S_AXI_WREADY_OUT  = ~w_hold_q & ~S_AXI_BVALID_OUT;
   assign do_write = aw_hold_q & w_hold_q;
   assign core_hit = (aw_idx_q == `IDX_CORE_CTRL)
                   | (aw_idx_q == `IDX_CORE_CTRL_B1)
                   | (aw_idx_q == `IDX_CORE_CTRL_B2)
                   | (aw_idx_q == `IDX_CORE_CTRL_B3);
   assign f1_hit  = do_write & w_strb_q & (aw_idx_q == `IDX_PERIPH_FLAGS1);
   assign f2_hit  = do_write & w_strb_q & (aw_idx_q == `IDX_PERIPH_FLAGS2);
   assign e1_hit  = do_write & w_strb_q & (aw_idx_q == `IDX_PERIPH_EN1);
   assign e2_hit  = do_write & w_strb_q & (aw_idx_q == `IDX_PERIPH_EN2);
   assign cfg_hit = do_write & w_strb_q & (aw_idx_q == `IDX_SRC_CFG);
   assign wr_ok   = core_hit | (aw_idx_q == `IDX_PERIPH_FLAGS1)
                  | (aw_idx_q == `IDX_PERIPH_FLAGS2)
                  | (aw_idx_q == `IDX_PERIPH_EN1)
                  | (aw_idx_q == `IDX_PERIPH_EN2)
                  | (aw_idx_q == `IDX_SRC_CFG);

   always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         aw_hold_q        <= 1'b0;
         aw_idx_q         <= 9'h000;
         w_hold_q         <= 1'b0;
         w_data_q         <= 8'h00;
         w_strb_q         <= 1'b0;
         S_AXI_BVALID_OUT <= 1'b0;
         S_AXI_BRESP_OUT  <= `RESP_OKAY;
      end else begin
         if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
            aw_hold_q <= 1'b1;
            aw_idx_q  <= S_AXI_AWADDR_IN[10:2];
         end
         if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
            w_hold_q <= 1'b1;
            w_data_q <= S_AXI_WDATA_IN[7:0];
            w_strb_q <= S_AXI_WSTRB_IN[0];
         end
         if (do_write) begin
            aw_hold_q        <= 1'b0;
            w_hold_q         <= 1'b0;
            S_AXI_BVALID_OUT <= 1'b1;
            S_AXI_BRESP_OUT  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
         end else if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
            S_AXI_BVALID_OUT <= 1'b0;
         end
      end
   end

   // core control: enables written, flags set by hardware win over clear
   always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         core_ctrl_q     <= `RST_CORE_CTRL;
         ext_edge_rise_q <= 1'b1;
      end else begin
         if (do_write && w_strb_q && core_hit) begin
            core_ctrl_q <= w_data_q;
         end
         if (cfg_hit) begin
            ext_edge_rise_q <= w_data_q[0];
         end
         if (TIMER_A_OVF_IN) begin
            core_ctrl_q[`BIT_TMRA_FLAG] <= 1'b1;
         end
         if (ext_edge) begin
            core_ctrl_q[`BIT_EXT_FLAG] <= 1'b1;
         end
         if (port_mismatch) begin
            core_ctrl_q[`BIT_PORT_FLAG] <= 1'b1;
         end
      end
   end

   // peripheral enables and flags
   always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         pen1_q   <= `RST_PERIPH;
         pen2_q   <= 1'b0;
         pflag1_q <= `RST_PERIPH;
         pflag2_q <= 1'b0;
      end else begin
         if (e1_hit) begin
            pen1_q <= w_data_q;
         end
         if (e2_hit) begin
            pen2_q <= w_data_q[0];
         end
         // set wins over a clear in the same cycle
         pflag1_q <= (f1_hit ? w_data_q : pflag1_q) | pset1;
         pflag2_q <= (f2_hit ? w_data_q[0] : pflag2_q) | pset2;
      end
   end

   // flag view with uart bits taken live from the buffers
   wire [7:0] pflag1_view;
   assign pflag1_view = {pflag1_q[7:6], UART_RX_FULL_IN,
                         UART_TX_EMPTY_IN, pflag1_q[3:0]};

   // combined request to the core
   always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         CORE_IRQ_OUT <= 1'b0;
      end else begin
         CORE_IRQ_OUT <= core_ctrl_q[`BIT_GLOBAL_EN] &
            ((|(core_ctrl_q[5:3] & core_ctrl_q[2:0])) |
             (core_ctrl_q[`BIT_PERIPH_EN] &
              ((|(pen1_q & pflag1_view)) | (pen2_q & pflag2_q))));
      end
   end

   // read decode
   assign S_AXI_ARREADY_OUT = ~S_AXI_RVALID_OUT;
   assign ar_idx = S_AXI_ARADDR_IN[10:2];
   always @* begin
      rd_val = 8'h00;
      rd_ok  = 1'b1;
      if (ar_idx == `IDX_CORE_CTRL || ar_idx == `IDX_CORE_CTRL_B1 ||
          ar_idx == `IDX_CORE_CTRL_B2 || ar_idx == `IDX_CORE_CTRL_B3) begin
         rd_val = core_ctrl_q;
      end else if (ar_idx == `IDX_PERIPH_FLAGS1) begin
         rd_val = pflag1_view;
      end else if (ar_idx == `IDX_PERIPH_FLAGS2) begin
         rd_val = {7'h00, pflag2_q};
      end else if (ar_idx == `IDX_PERIPH_EN1) begin
         rd_val = pen1_q;
      end else if (ar_idx == `IDX_PERIPH_EN2) begin
         rd_val = {7'h00, pen2_q};
      end else if (ar_idx == `IDX_SRC_CFG) begin
         rd_val = {7'h00, ext_edge_rise_q};
      end else begin
         rd_ok = 1'b0;
      end
   end

   always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         S_AXI_RVALID_OUT <= 1'b0;
         S_AXI_RDATA_OUT  <= 32'h00000000;
         S_AXI_RRESP_OUT  <= `RESP_OKAY;
      end else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
         S_AXI_RVALID_OUT <= 1'b1;
         S_AXI_RDATA_OUT  <= {24'h000000, rd_val};
         S_AXI_RRESP_OUT  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN) begin
         S_AXI_RVALID_OUT <= 1'b0;
      end
   end

endmodule // irq_flag_logic
`default_nettype wire

// ### bench/irq_flag_checker.sv
/* checker for irq_flag_logic: bus answers, narrow registers, irq.
   assumes it is bound to the block and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module irq_flag_checker (
   input wire logic        SYS_CLK_IN,
   input wire logic        RESETN_IN,
   input wire logic        S_AXI_AWVALID_IN,
   input wire logic        S_AXI_AWREADY_OUT,
   input wire logic        S_AXI_WVALID_IN,
   input wire logic        S_AXI_WREADY_OUT,
   input wire logic        S_AXI_BVALID_OUT,
   input wire logic        S_AXI_BREADY_IN,
   input wire logic [11:0] S_AXI_ARADDR_IN,
   input wire logic        S_AXI_ARVALID_IN,
   input wire logic        S_AXI_ARREADY_OUT,
   input wire logic [31:0] S_AXI_RDATA_OUT,
   input wire logic [1:0]  S_AXI_RRESP_OUT,
   input wire logic        S_AXI_RVALID_OUT,
   input wire logic        S_AXI_RREADY_IN,
   input wire logic        UART_RX_FULL_IN,
   input wire logic        UART_TX_EMPTY_IN,
   input wire logic        CORE_IRQ_OUT
);
   // read address taken this cycle
   wire take = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RESETN_IN);

   a_irq_reset_low: assert property (
      $rose(RESETN_IN) |-> !CORE_IRQ_OUT [*3]) else $error("irq after reset");
   a_read_answer: assert property (
      take |=> S_AXI_RVALID_OUT) else $error("read answer late");
   a_read_holds: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN
      |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT))
      else $error("read answer dropped");
   a_write_answer: assert property (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT
      && S_AXI_WVALID_IN && S_AXI_WREADY_OUT |-> ##[1:2] S_AXI_BVALID_OUT)
      else $error("write answer late");
   a_write_holds: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN
      |=> S_AXI_BVALID_OUT) else $error("write answer dropped");
   a_pend_refuse: assert property (S_AXI_BVALID_OUT || S_AXI_RVALID_OUT
      |-> !(S_AXI_AWREADY_OUT && S_AXI_BVALID_OUT) && !(S_AXI_ARREADY_OUT
      && S_AXI_RVALID_OUT)) else $error("request taken while pending");
   a_uart_live: assert property (
      take && S_AXI_ARADDR_IN == 12'h030 |=> S_AXI_RDATA_OUT[5:4] ==
      {$past(UART_RX_FULL_IN), $past(UART_TX_EMPTY_IN)}) else $error("uart");
   a_narrow_regs: assert property (
      take && (S_AXI_ARADDR_IN == 12'h034 || S_AXI_ARADDR_IN == 12'h234)
      |=> S_AXI_RDATA_OUT[31:1] == 31'h0) else $error("narrow reg bits");
   a_unmapped_err: assert property (take && S_AXI_ARADDR_IN == 12'h7fc
      |=> S_AXI_RRESP_OUT == 2'h2 && S_AXI_RDATA_OUT == 32'h0)
      else $error("unmapped read");
   // main scenarios
   c_write: cover property (S_AXI_BVALID_OUT && S_AXI_BREADY_IN);
   c_irq_up: cover property ($rose(CORE_IRQ_OUT));
   c_irq_down: cover property ($fell(CORE_IRQ_OUT));
endmodule // irq_flag_checker
`default_nettype wire

// ### bench/event_sources.sv
/* partner: on-chip event sources making one-cycle pulses.
   assumes kick strobes from the bench on the same clock. */
`timescale 1ns/1ns
`default_nettype none
module event_sources #(
   parameter SMALL_PKG = 0
) (
   input  wire logic       clk_in,
   input  wire logic [9:0] kick_in,
   output var  logic [9:0] pulse_out
);
   // pulse a cycle after each kick; no parallel port on small package
   always @(posedge clk_in) begin
      pulse_out <= kick_in;
      pulse_out[8] <= kick_in[8] && SMALL_PKG == 0;
   end
endmodule // event_sources
`default_nettype wire

// ### bench/irq_flag_logic_test.sv
/* testbench for irq_flag_logic: register reads and writes, events, irq.
   assumes event_sources and irq_flag_checker are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module irq_flag_logic_test;
   logic        c, rn, awv, wv, bre, arv, rre, ext, prd, rx, tx, idl, pw;
   logic [11:0] awa, ara;
   logic [31:0] wd;
   logic [3:0]  pins;
   logic [9:0]  kk;
   logic [45:0] q[$];
   logic [45:0] nt;
   int          failures, n_tests, i;
   wire         awr, wrd, bv, arr, rv, irq;
   wire [1:0]   br, rr;
   wire [31:0]  rdat;
   wire [9:0]   ev;
   wire [7:0]   uf = {2'b00, rx, tx, 4'h0};

   event_sources src (.clk_in(c), .kick_in(kk), .pulse_out(ev));
   irq_flag_logic dut (
      .SYS_CLK_IN(c), .RESETN_IN(rn), .S_AXI_AWADDR_IN(awa),
      .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd),
      .S_AXI_WSTRB_IN(4'hf), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrd),
      .S_AXI_BRESP_OUT(br), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(bre),
      .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv),
      .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rdat), .S_AXI_RRESP_OUT(rr),
      .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rre), .TIMER_A_OVF_IN(ev[9]),
      .EXT_IRQ_PIN_IN(ext), .PORT_PINS_IN(pins), .PORT_READ_IN(prd),
      .PARALLEL_PORT_EVT_IN(ev[8]), .ADC_DONE_IN(ev[7]),
      .UART_RX_FULL_IN(rx), .UART_TX_EMPTY_IN(tx),
      .SERIAL_XFER_DONE_IN(ev[6]), .SERIAL_COND_DONE_IN(ev[5]),
      .SERIAL_BUS_COND_IN(ev[4]), .SERIAL_IDLE_IN(idl),
      .CAPCMP_ONE_EVT_IN(ev[3]), .CAPCMP_ONE_PWM_IN(pw),
      .CAPCMP_TWO_EVT_IN(ev[2]), .CAPCMP_TWO_PWM_IN(pw),
      .TIMER_C_MATCH_IN(ev[1]), .TIMER_B_OVF_IN(ev[0]), .CORE_IRQ_OUT(irq));

   // 25 MHz clock
   initial begin
      c = 0;
      forever #20 c = ~c;
   end

   task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask

   task final_report;
      if (failures == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // write one register; address and data released as each is taken
   task automatic wr(logic [11:0] a, logic [7:0] d);
      int n;
      n = 0;
      @(posedge c);
      awa <= a;
      wd <= {24'h0, d};
      awv <= 1;
      wv <= 1;
      bre <= 1;
      do begin
         @(posedge c);
         if (awr) awv <= 0;
         if (wrd) wv <= 0;
         n++;
      end while (!bv && n < 50);
      bre <= 0;
      failures += (n >= 50);
   endtask

   // read one register, noting the expected answer first
   task automatic rd(logic [11:0] a, logic [31:0] e, logic [1:0] r = 0);
      int n;
      n = 0;
      q.push_back({a, e, r});
      @(posedge c);
      ara <= a;
      arv <= 1;
      rre <= 1;
      do begin
         @(posedge c);
         if (arr) arv <= 0;
         n++;
      end while (!rv && n < 50);
      rre <= 0;
      failures += (n >= 50);
   endtask

   task automatic kick(logic [9:0] k);
      @(posedge c);
      kk <= k;
      @(posedge c);
      kk <= 0;
   endtask

   // match every read answer with the oldest note
   always @(posedge c) begin
      if (rv && rre) begin
         nt = q.pop_front();
         chk("rdata", rdat, nt[33:2]);
         chk("rresp", {30'h0, rr}, {30'h0, nt[1:0]});
      end
   end

   // watchdog
   initial begin
      repeat (20000) @(posedge c);
      failures++;
      final_report;
   end

   // main sequence
   initial begin
      {awv, wv, bre, arv, rre, ext, prd, pw, rn} = 0;
      {awa, ara, wd, pins, kk, failures, n_tests} = 0;
      idl = 1;
      void'($urandom(32'ha8f1d731));
      {rx, tx} = 2'($urandom);
      repeat (20) @(posedge c);
      rn <= 1;
      for (i = 0; i < 4; i++) rd(12'(12'h02c + 12'h200 * i), 0);
      rd(12'h030, uf);
      rd(12'h034, 0);
      rd(12'h230, 0);
      rd(12'h234, 0);
      rd(12'h7fc, 0, 2'b10);
      // core sources while the global enable is off
      wr(12'h62c, 8'h38);
      kick(10'h200);
      ext <= 1;
      pins <= 4'h5;
      repeat (6) @(posedge c);
      chk("irq", irq, 0);
      rd(12'h22c, 32'h3f);
      wr(12'h42c, 8'hbf);
      repeat (3) @(posedge c);
      chk("irq", irq, 1);
      wr(12'h02c, 8'hb8);
      rd(12'h02c, 32'hb9);
      prd <= 1;
      @(posedge c);
      prd <= 0;
      wr(12'h02c, 8'h80);
      rd(12'h02c, 32'h80);
      // falling edge selected on the external pin
      wr(12'h7c0, 8'h00);
      rd(12'h7c0, 0);
      ext <= 0;
      repeat (6) @(posedge c);
      rd(12'h02c, 32'h82);
      wr(12'h02c, 8'h80);
      rd(12'h02c, 32'h80);
      // peripheral sources; flags are clear before enabling
      wr(12'h230, 8'hff);
      wr(12'h234, 8'hff);
      rd(12'h234, 1);
      for (i = 0; i < 4; i++) begin
         idl <= (i < 3);
         kick(10'h040 >> (i > 2 ? 2 : i));
         rd(12'h030, uf | (i < 3 ? 8'h08 : 8'h00));
         wr(12'h030, 8'h00);
      end
      pw <= 1;
      kick(10'h18f);
      rd(12'h030, uf | 8'hc3);
      rd(12'h034, 0);
      chk("irq", irq, 0);
      pw <= 0;
      kick(10'h00c);
      rd(12'h030, uf | 8'hc7);
      rd(12'h034, 1);
      wr(12'h02c, 8'hc0);
      repeat (3) @(posedge c);
      chk("irq", irq, 1);
      wr(12'h230, 8'h00);
      wr(12'h234, 8'h00);
      repeat (3) @(posedge c);
      chk("irq", irq, 0);
      final_report;
   end
endmodule // irq_flag_logic_test

bind irq_flag_logic irq_flag_checker chk_i (.*);
`default_nettype wire
